// ==== rtl/fcq_host.sv ====
// Host controller that drives a parallel NOR flash by command cycles
// Behaviour
// - Host issues only defined command codes, never reserved ones.
// - After buffered write setup, host checks status before loading data.
// - Count N gives N+1 data writes; limits 1F byte, 0F word.
// - Confirm D0 follows exactly N+1 data writes; otherwise aborts.
// - In eight-bit mode host drives lowest address line.
// - Codes FF read array, E8 buffer setup, B0 suspend.
`default_nettype none
module fcq_host
   import fcq_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Command request
   input wire logic i_cmd_valid,
   input wire fcq_op_t i_cmd_op,
   input wire logic [23:0] i_cmd_addr,
   input wire logic [15:0] i_cmd_data,
   input wire logic [4:0] i_cmd_count,
   input wire logic i_x8_mode,
   output logic o_cmd_ready,
   // Buffered write data
   input wire logic i_wdata_valid,
   input wire logic [15:0] i_wdata,
   output logic o_wdata_ready,
   // Results
   output logic o_done,
   output logic [31:0] o_rd_data,
   output logic o_dev_busy,
   output logic o_dev_suspended,
   // Flash pins
   output logic [23:0] o_flash_addr,
   output logic o_flash_ce_n,
   output logic o_flash_oe_n,
   output logic o_flash_we_n,
   output logic o_flash_byte_n,
   output logic [15:0] o_flash_dq_out,
   output logic o_flash_dq_oe,
   input wire logic [15:0] i_flash_dq
);
   typedef enum logic [3:0]
   {
      FCQ_S_IDLE, FCQ_S_CMD1, FCQ_S_CMD2, FCQ_S_XSR, FCQ_S_COUNT,
      FCQ_S_DATA, FCQ_S_CONFIRM, FCQ_S_POLL, FCQ_S_READ, FCQ_S_DONE
   } fcq_state_t;

   fcq_state_t state_q, state_d;
   fcq_op_t op_q, op_d;
   fcq_mode_t mode_q, mode_d;
   logic [23:0] addr_q, addr_d;
   logic [15:0] data_q, data_d, wbuf_q, wbuf_d;
   logic [4:0] count_q, count_d, left_q, left_d;
   logic [1:0] idx_q, idx_d;
   logic launched_q, launched_d, have_q, have_d, pend_q, pend_d;
   logic busy_q, busy_d, susp_q, susp_d;
   logic ready_q, ready_d, wready_q, wready_d, done_q, done_d, byte_n_q;
   logic [31:0] rd_q, rd_d;
   logic start, wr;
   logic [23:0] cyc_addr;
   logic [15:0] cyc_data, cyc_rdata;
   logic cyc_done;
   logic [4:0] count_max;

   function automatic logic [7:0] first_code(input fcq_op_t op);
      case (op)
         FCQ_OP_READ_ARRAY: first_code = FCQ_CODE_READ_ARRAY;
         FCQ_OP_READ_QUERY: first_code = FCQ_CODE_READ_QUERY;
         FCQ_OP_READ_STATUS: first_code = FCQ_CODE_READ_STATUS;
         FCQ_OP_CLEAR_STATUS: first_code = FCQ_CODE_CLEAR_STATUS;
         FCQ_OP_PROGRAM: first_code = FCQ_CODE_PROG_SETUP;
         FCQ_OP_BUF_WRITE: first_code = FCQ_CODE_BUF_SETUP;
         FCQ_OP_ERASE: first_code = FCQ_CODE_ERASE_SETUP;
         FCQ_OP_SUSPEND: first_code = FCQ_CODE_SUSPEND;
         FCQ_OP_RESUME: first_code = FCQ_CODE_CONFIRM;
         FCQ_OP_CLEAR_LOCKS: first_code = FCQ_CODE_LOCK_SETUP;
         FCQ_OP_CONFIG: first_code = FCQ_CODE_CONFIG;
         default: first_code = FCQ_CODE_READ_ARRAY;
      endcase
   endfunction

   assign count_max = i_x8_mode ? FCQ_BUF_MAX_BYTE : FCQ_BUF_MAX_WORD;

   always_comb
   begin
      state_d = state_q;
      op_d = op_q;
      mode_d = mode_q;
      addr_d = addr_q;
      data_d = data_q;
      wbuf_d = wbuf_q;
      count_d = count_q;
      left_d = left_q;
      idx_d = idx_q;
      launched_d = launched_q;
      have_d = have_q;
      pend_d = pend_q;
      busy_d = busy_q;
      susp_d = susp_q;
      done_d = 1'b0;
      rd_d = rd_q;
      start = 1'b0;
      wr = 1'b1;
      cyc_addr = addr_q;
      cyc_data = {8'h00, first_code(op_q)};
      if (state_q != FCQ_S_IDLE && state_q != FCQ_S_DONE && !launched_q)
      begin
         start = (state_q != FCQ_S_DATA) || have_q;
         launched_d = start;
      end
      if (cyc_done)
      begin
         launched_d = 1'b0;
      end
      case (state_q)
         FCQ_S_IDLE:
         begin
            if (i_cmd_valid && ready_q)
            begin
               op_d = i_cmd_op;
               addr_d = i_cmd_addr;
               data_d = i_cmd_data;
               count_d = (i_cmd_count > count_max) ? count_max : i_cmd_count;
               idx_d = 2'h0;
               rd_d = 32'h0000_0000;
               pend_d = 1'b0;
               if (i_cmd_op == FCQ_OP_READ_QUERY)
               begin
                  // Offset in max-width units on A23..A1
                  // Same pins give byte address 2n in x8
                  addr_d = {i_cmd_addr[22:0], 1'b0};
               end
               // Wait out a running operation first
               if (i_cmd_op == FCQ_OP_READ_ARRAY && busy_q && !susp_q)
               begin
                  pend_d = 1'b1;
                  state_d = FCQ_S_POLL;
               end
               // Mode already held, skip the command
               else if ((i_cmd_op == FCQ_OP_READ_ARRAY && mode_q == FCQ_MODE_ARRAY) ||
                  (i_cmd_op == FCQ_OP_READ_QUERY && mode_q == FCQ_MODE_QUERY) ||
                  (i_cmd_op == FCQ_OP_READ_STATUS && mode_q == FCQ_MODE_STATUS))
               begin
                  state_d = FCQ_S_READ;
               end
               else
               begin
                  state_d = FCQ_S_CMD1;
               end
            end
         end
         FCQ_S_CMD1:
         begin
            if (cyc_done)
            begin
               mode_d = FCQ_MODE_STATUS;
               case (op_q)
                  FCQ_OP_READ_ARRAY:
                  begin
                     mode_d = FCQ_MODE_ARRAY;
                     susp_d = 1'b0;
                     state_d = FCQ_S_READ;
                  end
                  FCQ_OP_READ_QUERY:
                  begin
                     mode_d = FCQ_MODE_QUERY;
                     state_d = FCQ_S_READ;
                  end
                  FCQ_OP_READ_STATUS: state_d = FCQ_S_READ;
                  FCQ_OP_CLEAR_STATUS:
                  begin
                     mode_d = mode_q;
                     state_d = FCQ_S_DONE;
                  end
                  FCQ_OP_SUSPEND: state_d = FCQ_S_POLL;
                  FCQ_OP_RESUME:
                  begin
                     busy_d = 1'b1;
                     susp_d = 1'b0;
                     state_d = FCQ_S_DONE;
                  end
                  FCQ_OP_BUF_WRITE: state_d = FCQ_S_XSR;
                  default: state_d = FCQ_S_CMD2;
               endcase
            end
         end
         FCQ_S_CMD2:
         begin
            // Erase and lock clear need confirm
            cyc_data = {8'h00, FCQ_CODE_CONFIRM};
            if (op_q == FCQ_OP_PROGRAM)
            begin
               cyc_data = data_q;
            end
            else if (op_q == FCQ_OP_CONFIG)
            begin
               cyc_data = {8'h00, data_q[7:0]};
            end
            if (cyc_done)
            begin
               busy_d = (op_q != FCQ_OP_CONFIG);
               state_d = (op_q == FCQ_OP_CONFIG) ? FCQ_S_DONE : FCQ_S_POLL;
            end
         end
         FCQ_S_XSR:
         begin
            wr = 1'b0;
            if (cyc_done)
            begin
               // Reissue setup until a buffer is free
               state_d = cyc_rdata[FCQ_STATUS_READY_BIT] ? FCQ_S_COUNT : FCQ_S_CMD1;
            end
         end
         FCQ_S_COUNT:
         begin
            cyc_data = {11'h000, count_q};
            if (cyc_done)
            begin
               left_d = count_q;
               state_d = FCQ_S_DATA;
            end
         end
         FCQ_S_DATA:
         begin
            cyc_data = wbuf_q;
            if (wready_q && i_wdata_valid)
            begin
               wbuf_d = i_wdata;
               have_d = 1'b1;
            end
            if (cyc_done)
            begin
               have_d = 1'b0;
               addr_d = addr_q + (i_x8_mode ? 24'h00_0001 : 24'h00_0002);
               left_d = left_q - 5'h01;
               if (left_q == 5'h00)
               begin
                  state_d = FCQ_S_CONFIRM;
               end
            end
         end
         FCQ_S_CONFIRM:
         begin
            cyc_data = {8'h00, FCQ_CODE_CONFIRM};
            if (cyc_done)
            begin
               busy_d = 1'b1;
               state_d = FCQ_S_POLL;
            end
         end
         FCQ_S_POLL:
         begin
            wr = 1'b0;
            if (cyc_done)
            begin
               rd_d = {16'h0000, cyc_rdata};
               // Only bit 7 is valid while busy
               if (cyc_rdata[FCQ_STATUS_READY_BIT])
               begin
                  if (op_q == FCQ_OP_SUSPEND)
                  begin
                     susp_d = 1'b1;
                  end
                  else
                  begin
                     busy_d = 1'b0;
                  end
                  state_d = pend_q ? FCQ_S_CMD1 : FCQ_S_DONE;
               end
            end
         end
         FCQ_S_READ:
         begin
            wr = 1'b0;
            if (cyc_done)
            begin
               if (op_q == FCQ_OP_READ_QUERY)
               begin
                  rd_d[8 * idx_q +: 8] = cyc_rdata[7:0];
                  idx_d = idx_q + 2'h1;
                  // A0 driven, next offset two bytes on
                  addr_d = addr_q + 24'h00_0002;
                  if (idx_q == FCQ_QUERY_MAX_IDX || {3'h0, idx_q} == count_q)
                  begin
                     state_d = FCQ_S_DONE;
                  end
               end
               else
               begin
                  rd_d = {16'h0000, cyc_rdata};
                  state_d = FCQ_S_DONE;
               end
            end
         end
         FCQ_S_DONE:
         begin
            done_d = 1'b1;
            state_d = FCQ_S_IDLE;
         end
         default:
         begin
            state_d = FCQ_S_IDLE;
         end
      endcase
      ready_d = (state_d == FCQ_S_IDLE);
      wready_d = (state_d == FCQ_S_DATA) && !have_d && !(state_q == FCQ_S_DATA && wready_q && i_wdata_valid);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_q <= FCQ_S_IDLE;
         op_q <= FCQ_OP_READ_ARRAY;
         // No config write, page mode kept
         mode_q <= FCQ_MODE_ARRAY;
         addr_q <= 24'h00_0000;
         data_q <= 16'h0000;
         wbuf_q <= 16'h0000;
         count_q <= 5'h00;
         left_q <= 5'h00;
         idx_q <= 2'h0;
         launched_q <= 1'b0;
         have_q <= 1'b0;
         pend_q <= 1'b0;
         busy_q <= 1'b0;
         susp_q <= 1'b0;
         ready_q <= 1'b0;
         wready_q <= 1'b0;
         done_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         byte_n_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         op_q <= op_d;
         mode_q <= mode_d;
         addr_q <= addr_d;
         data_q <= data_d;
         wbuf_q <= wbuf_d;
         count_q <= count_d;
         left_q <= left_d;
         idx_q <= idx_d;
         launched_q <= launched_d;
         have_q <= have_d;
         pend_q <= pend_d;
         busy_q <= busy_d;
         susp_q <= susp_d;
         ready_q <= ready_d;
         wready_q <= wready_d;
         done_q <= done_d;
         rd_q <= rd_d;
         byte_n_q <= ~i_x8_mode;
      end
   end

   fcq_bus_cycle u_cycle
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_start(start),
      .i_write(wr),
      .i_addr(cyc_addr),
      .i_data(cyc_data),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_addr(o_flash_addr),
      .o_ce_n(o_flash_ce_n),
      .o_oe_n(o_flash_oe_n),
      .o_we_n(o_flash_we_n),
      .o_dq_out(o_flash_dq_out),
      .o_dq_oe(o_flash_dq_oe),
      .i_dq(i_flash_dq)
   );

   assign o_cmd_ready = ready_q;
   assign o_wdata_ready = wready_q;
   assign o_done = done_q;
   assign o_rd_data = rd_q;
   assign o_dev_busy = busy_q;
   assign o_dev_suspended = susp_q;
   assign o_flash_byte_n = byte_n_q;
endmodule
`default_nettype wire

// ==== rtl/fcq_pkg.sv ====
// Shared constants and types for the flash command host
`default_nettype none
package fcq_pkg;
   // Command codes sent on the low data byte
   localparam logic [7:0] FCQ_CODE_READ_ARRAY = 8'hFF;
   localparam logic [7:0] FCQ_CODE_READ_QUERY = 8'h98;
   localparam logic [7:0] FCQ_CODE_READ_STATUS = 8'h70;
   localparam logic [7:0] FCQ_CODE_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] FCQ_CODE_BUF_SETUP = 8'hE8;
   localparam logic [7:0] FCQ_CODE_PROG_SETUP = 8'h40;
   localparam logic [7:0] FCQ_CODE_ERASE_SETUP = 8'h20;
   localparam logic [7:0] FCQ_CODE_SUSPEND = 8'hB0;
   localparam logic [7:0] FCQ_CODE_CONFIRM = 8'hD0;
   localparam logic [7:0] FCQ_CODE_CONFIG = 8'hB8;
   localparam logic [7:0] FCQ_CODE_LOCK_SETUP = 8'h60;
   // Buffered write count limits
   localparam logic [4:0] FCQ_BUF_MAX_BYTE = 5'h1F;
   localparam logic [4:0] FCQ_BUF_MAX_WORD = 5'h0F;
   // Status bit that reports the write state machine ready
   localparam int FCQ_STATUS_READY_BIT = 7;
   // Last query byte index; query reads return at most four bytes
   localparam logic [1:0] FCQ_QUERY_MAX_IDX = 2'h3;
   // Bus timing
   localparam int FCQ_CLK_PERIOD_NS = 50;
   localparam int FCQ_T_STROBE_NS = 150;
   localparam int FCQ_T_RECOVER_NS = 50;
   localparam logic [2:0] FCQ_STROBE_CYC =
      3'((FCQ_T_STROBE_NS + FCQ_CLK_PERIOD_NS - 1) / FCQ_CLK_PERIOD_NS);
   localparam logic [2:0] FCQ_RECOVER_CYC =
      3'((FCQ_T_RECOVER_NS + FCQ_CLK_PERIOD_NS - 1) / FCQ_CLK_PERIOD_NS);

   typedef enum logic [3:0]
   {
      FCQ_OP_READ_ARRAY,
      FCQ_OP_READ_QUERY,
      FCQ_OP_READ_STATUS,
      FCQ_OP_CLEAR_STATUS,
      FCQ_OP_PROGRAM,
      FCQ_OP_BUF_WRITE,
      FCQ_OP_ERASE,
      FCQ_OP_SUSPEND,
      FCQ_OP_RESUME,
      FCQ_OP_CLEAR_LOCKS,
      FCQ_OP_CONFIG
   } fcq_op_t;

   typedef enum logic [1:0]
   {
      FCQ_MODE_ARRAY,
      FCQ_MODE_QUERY,
      FCQ_MODE_STATUS,
      FCQ_MODE_OTHER
   } fcq_mode_t;
endpackage
`default_nettype wire

// ==== rtl/fcq_bus_cycle.sv ====
// One asynchronous read or write cycle on the flash pins
`default_nettype none
module fcq_bus_cycle
   import fcq_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Cycle request
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [23:0] i_addr,
   input wire logic [15:0] i_data,
   output logic o_done,
   output logic [15:0] o_rdata,
   // Flash pins
   output logic [23:0] o_addr,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [15:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [15:0] i_dq
);
   typedef enum logic [1:0] {FCQ_CY_IDLE, FCQ_CY_SETUP, FCQ_CY_STROBE, FCQ_CY_RECOVER} fcq_cy_t;

   fcq_cy_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic wr_q, wr_d;
   logic [23:0] addr_q, addr_d;
   logic [15:0] dout_q, dout_d, rdata_q, rdata_d;
   logic oe_q, oe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, done_q, done_d;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      addr_d = addr_q;
      dout_d = dout_q;
      rdata_d = rdata_q;
      oe_d = oe_q;
      ce_n_d = ce_n_q;
      oe_n_d = oe_n_q;
      we_n_d = we_n_q;
      done_d = 1'b0;
      case (state_q)
         FCQ_CY_IDLE:
         begin
            if (i_start)
            begin
               wr_d = i_write;
               addr_d = i_addr;
               dout_d = i_data;
               oe_d = i_write;
               ce_n_d = 1'b0;
               state_d = FCQ_CY_SETUP;
            end
         end
         FCQ_CY_SETUP:
         begin
            we_n_d = ~wr_q;
            oe_n_d = wr_q;
            cnt_d = FCQ_STROBE_CYC - 3'h1;
            state_d = FCQ_CY_STROBE;
         end
         FCQ_CY_STROBE:
         begin
            if (cnt_q == 3'h0)
            begin
               we_n_d = 1'b1;
               oe_n_d = 1'b1;
               if (!wr_q)
               begin
                  rdata_d = i_dq;
               end
               cnt_d = FCQ_RECOVER_CYC - 3'h1;
               state_d = FCQ_CY_RECOVER;
            end
            else
            begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         FCQ_CY_RECOVER:
         begin
            if (cnt_q == 3'h0)
            begin
               ce_n_d = 1'b1;
               oe_d = 1'b0;
               done_d = 1'b1;
               state_d = FCQ_CY_IDLE;
            end
            else
            begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         default:
         begin
            state_d = FCQ_CY_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_q <= FCQ_CY_IDLE;
         cnt_q <= 3'h0;
         wr_q <= 1'b0;
         addr_q <= 24'h00_0000;
         dout_q <= 16'h0000;
         rdata_q <= 16'h0000;
         oe_q <= 1'b0;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         dout_q <= dout_d;
         rdata_q <= rdata_d;
         oe_q <= oe_d;
         ce_n_q <= ce_n_d;
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         done_q <= done_d;
      end
   end

   assign o_done = done_q;
   assign o_rdata = rdata_q;
   assign o_addr = addr_q;
   assign o_ce_n = ce_n_q;
   assign o_oe_n = oe_n_q;
   assign o_we_n = we_n_q;
   assign o_dq_out = dout_q;
   assign o_dq_oe = oe_q;
endmodule
`default_nettype wire

// ==== tb/fcq_host_monitor.sv ====
// Pin protocol checker for the flash command host
`default_nettype none
module fcq_host_monitor
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Command side
   input wire logic i_cmd_valid,
   input wire logic o_cmd_ready,
   input wire logic o_done,
   // Flash pins
   input wire logic o_flash_ce_n,
   input wire logic o_flash_oe_n,
   input wire logic o_flash_we_n,
   input wire logic [15:0] o_flash_dq_out,
   input wire logic o_flash_dq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_strobe_excl: assert property (o_flash_oe_n || o_flash_we_n)
      else $error("read and write strobes low together");
   a_we_width: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*3] ##1 o_flash_we_n)
      else $error("write strobe not three cycles low");
   a_data_hold: assert property ($rose(o_flash_we_n) |->
         o_flash_dq_oe && !o_flash_ce_n && $stable(o_flash_dq_out))
      else $error("write data not held past strobe rise");
   a_write_drive: assert property (!o_flash_we_n |-> o_flash_dq_oe && !o_flash_ce_n)
      else $error("write strobe without driven data");
   a_read_float: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && !o_flash_ce_n)
      else $error("host drives data during a read");
   // Reset must idle the pins even while it is held
   a_reset_idle: assert property (disable iff (1'b0) i_srst |=>
         o_flash_ce_n && o_flash_oe_n && o_flash_we_n && !o_flash_dq_oe && !o_cmd_ready && !o_done)
      else $error("pins not idle after reset");
   a_done_pulse: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   a_take_busy: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready [*2])
      else $error("ready stayed high after a take");
   a_idle_bus: assert property (o_cmd_ready |-> o_flash_ce_n && !o_flash_dq_oe)
      else $error("bus active while ready");

   c_write: cover property ($rose(o_flash_we_n));
   c_read: cover property ($rose(o_flash_oe_n));
   c_take: cover property (i_cmd_valid && o_cmd_ready);
endmodule
`default_nettype wire

// ==== tb/fcq_flash_model.sv ====
// Behavioural flash device answering the host pins
`default_nettype none
module fcq_flash_model
(
   // Clock
   input wire logic i_clk,
   // Flash pins
   input wire logic [23:0] i_addr,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq
);
   timeunit 1ns;
   timeprecision 1ns;
   int busy = 0;
   int nxt = 0;
   int left = 0;
   int words = 0;
   int bad = 0;
   logic [1:0] mode = 2'h0;
   logic susp = 1'b0;
   logic locks = 1'b1;
   logic [7:0] setup = 8'h00;
   logic [15:0] pdata = 16'h0000;
   logic [7:0] c;
   logic [7:0] q;

   // latch on strobe rise, low byte for commands, whole word for program data
   // Start-up strobe edge out of unknown is no write
   always @(posedge i_we_n)
      if (!i_ce_n)
      begin
         c = i_dq[7:0];
         case (nxt)
            // program data after either setup code
            1:
            begin
               pdata = i_dq;
               busy = 20;
               mode = 2'h2;
               nxt = 0;
            end
            2:
            begin
               left = c;
               words = 0;
               nxt = 3;
            end
            3:
            begin
               words++;
               nxt = (words == left + 1) ? 4 : 3;
            end
            // start only on confirm, all locks at once
            4:
            begin
               busy = (c == 8'hD0) ? 20 : 0;
               locks = (c == 8'hD0 && setup == 8'h60) ? 1'b0 : locks;
               mode = 2'h2;
               nxt = 0;
            end
            5:
               nxt = 0;
            default:
            begin
               // first buffer request finds none free
               busy = (c == 8'hE8 && setup != 8'hE8) ? 8 : busy;
               setup = c;
               case (c)
                  8'hFF: mode = (busy == 0 || susp) ? 2'h0 : mode;
                  8'h98: mode = 2'h1;
                  8'h70, 8'hE8, 8'hB0: mode = 2'h2;
                  8'h40, 8'h10: nxt = 1;
                  8'h20, 8'h60: nxt = 4;
                  8'hB8: nxt = 5;
                  8'hD0, 8'h50: mode = mode;
                  default: bad++;
               endcase
               nxt = (c == 8'hE8 && busy == 0) ? 2 : nxt;
               susp = (c == 8'hB0) || (susp && c != 8'hD0);
            end
         endcase
      end

   always @(posedge i_clk)
      if (busy > 0 && !susp)
         busy--;

   // offset from address over two, low byte first
   always_comb
   begin
      case (i_addr[8:1])
         8'h10: q = 8'h51;
         8'h11: q = 8'h52;
         8'h12: q = 8'h59;
         8'h13: q = 8'h01;
         default: q = 8'h00;
      endcase
      // Released lines toggle so stale data never looks valid
      o_dq = {16{i_clk}} ^ 16'hA5A5;
      if (!i_ce_n && !i_oe_n)
         case (mode)
            2'h0: o_dq = i_addr[15:0] ^ 16'hC3A5;
            2'h1: o_dq = {8'h00, q};
            // busy status drives bit 7 only
            default: o_dq = (busy > 0 && !susp) ? {o_dq[15:8], 1'b0, o_dq[6:0]} : 16'h0080;
         endcase
   end
endmodule
`default_nettype wire

// ==== tb/fcq_host_tb.sv ====
// Self-checking bench for the flash command host
`default_nettype none
module fcq_host_tb
   import fcq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_cmd_valid = 1'b0;
   fcq_op_t i_cmd_op = FCQ_OP_READ_ARRAY;
   logic [23:0] i_cmd_addr = 24'h00_0000;
   logic [15:0] i_cmd_data = 16'h0000;
   logic [4:0] i_cmd_count = 5'h00;
   logic i_x8_mode = 1'b0;
   logic i_wdata_valid = 1'b1;
   logic [15:0] i_wdata = 16'h1000;
   logic o_cmd_ready, o_wdata_ready, o_done, o_dev_busy, o_dev_suspended;
   logic [31:0] o_rd_data;
   logic [23:0] o_flash_addr;
   logic o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_byte_n, o_flash_dq_oe;
   logic [15:0] o_flash_dq_out, i_flash_dq;
   int num_errors = 0;
   int n_tests = 0;

   fcq_host u_dut (.i_clk, .i_srst, .i_cmd_valid, .i_cmd_op, .i_cmd_addr, .i_cmd_data, .i_cmd_count,
      .i_x8_mode, .o_cmd_ready, .i_wdata_valid, .i_wdata, .o_wdata_ready, .o_done, .o_rd_data,
      .o_dev_busy, .o_dev_suspended, .o_flash_addr, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n,
      .o_flash_byte_n, .o_flash_dq_out, .o_flash_dq_oe, .i_flash_dq);
   fcq_flash_model u_dev (.i_clk, .i_addr(o_flash_addr), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
      .i_we_n(o_flash_we_n), .i_dq(o_flash_dq_out), .o_dq(i_flash_dq));

   always #25 i_clk = ~i_clk;

   // Fresh word after each take
   always @(posedge i_clk)
      if (i_wdata_valid && o_wdata_ready)
         i_wdata <= i_wdata + 16'h0001;

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Entered at a falling edge; request held until taken
   task automatic cmd(input fcq_op_t op, input logic [23:0] a, input logic [15:0] d, input logic [4:0] n);
      int k;
      i_cmd_op = op;
      i_cmd_addr = a;
      i_cmd_data = d;
      i_cmd_count = n;
      i_cmd_valid = 1'b1;
      for (k = 0; k < 20 && o_cmd_ready !== 1'b1; k++)
         @(negedge i_clk);
      // Never taken counts as a hang
      if (k >= 20)
         k = 3000;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      while (o_done !== 1'b1 && k < 3000)
      begin
         @(negedge i_clk);
         k++;
      end
      if (k >= 3000)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask

   task automatic t_reset();
      chk("idle pins", 32'h0000_000E, {o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_dq_oe});
      cmd(FCQ_OP_READ_ARRAY, 24'h00_0100, 16'h0000, 5'h00);
      chk("array data", 32'h0000_C2A5, o_rd_data);
      $display("test reset done");
   endtask

   task automatic t_program();
      cmd(FCQ_OP_PROGRAM, 24'h00_0200, 16'h1234, 5'h00);
      chk("program data", 32'h0000_1234, {16'h0000, u_dev.pdata});
      chk("busy", 32'h0000_0000, {31'h0, o_dev_busy});
      cmd(FCQ_OP_READ_ARRAY, 24'h00_0200, 16'h0000, 5'h00);
      chk("array after program", 32'h0000_C1A5, o_rd_data);
      $display("test program done");
   endtask

   task automatic t_buf(input logic x8, input logic [4:0] n, input int w);
      i_x8_mode = x8;
      cmd(FCQ_OP_BUF_WRITE, 24'h00_1000, 16'h0000, n);
      chk("buffer words", w, u_dev.words);
      chk("confirm seen", 32'h0000_0000, u_dev.nxt);
      chk("busy", 32'h0000_0000, {31'h0, o_dev_busy});
      chk("byte select", {31'h0, ~x8}, {31'h0, o_flash_byte_n});
      $display("test buffer done");
   endtask

   task automatic t_query(input logic x8);
      i_x8_mode = x8;
      cmd(FCQ_OP_READ_QUERY, 24'h00_0010, 16'h0000, 5'h03);
      chk("query bytes", 32'h0159_5251, o_rd_data);
      i_x8_mode = 1'b0;
      $display("test query done");
   endtask

   task automatic t_susp();
      cmd(FCQ_OP_SUSPEND, 24'h00_0000, 16'h0000, 5'h00);
      chk("suspended", 32'h0000_0001, {31'h0, o_dev_suspended});
      cmd(FCQ_OP_RESUME, 24'h00_0000, 16'h0000, 5'h00);
      cmd(FCQ_OP_READ_ARRAY, 24'h00_0300, 16'h0000, 5'h00);
      chk("array after resume", 32'h0000_C0A5, o_rd_data);
      chk("flags", 32'h0000_0000, {30'h0, o_dev_busy, o_dev_suspended});
      $display("test suspend done");
   endtask

   task automatic t_misc();
      cmd(FCQ_OP_ERASE, 24'h02_0000, 16'h0000, 5'h00);
      cmd(FCQ_OP_CLEAR_LOCKS, 24'h00_0000, 16'h0000, 5'h00);
      chk("locks", 32'h0000_0000, {31'h0, u_dev.locks});
      cmd(FCQ_OP_CONFIG, 24'h00_0000, 16'h0000, 5'h00);
      cmd(FCQ_OP_CLEAR_STATUS, 24'h00_0000, 16'h0000, 5'h00);
      cmd(FCQ_OP_READ_STATUS, 24'h00_0000, 16'h0000, 5'h00);
      chk("status", 32'h0000_0080, o_rd_data);
      chk("reserved codes", 32'h0000_0000, u_dev.bad);
      $display("test misc done");
   endtask

   initial
   begin
      repeat (2) @(negedge i_clk);
      i_srst = 1'b0;
      @(negedge i_clk);
      t_reset();
      t_program();
      t_buf(1'b0, 5'h00, 1);
      t_buf(1'b0, 5'h1F, 16);
      t_buf(1'b1, 5'h1F, 32);
      t_query(1'b0);
      t_query(1'b1);
      t_susp();
      t_misc();
      tally_and_finish();
   end
endmodule

bind fcq_host fcq_host_monitor u_mon (.i_clk, .i_srst, .i_cmd_valid, .o_cmd_ready, .o_done, .o_flash_ce_n,
   .o_flash_oe_n, .o_flash_we_n, .o_flash_dq_out, .o_flash_dq_oe);
`default_nettype wire
